// ---- verilog/adc_conv_pkg.sv ----
// Constants and types for the converter control block
package adc_conv_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_CTRL0 = 12'hF70;
  localparam logic [11:0] IDX_CTRL1 = 12'hF71;
  localparam logic [11:0] IDX_RES_HI = 12'hF72;
  localparam logic [11:0] IDX_RES_LO = 12'hF73;
  localparam logic [11:0] IDX_IRQ_STAT = 12'hF74;
  localparam logic [11:0] IDX_IRQ_MASK = 12'hF75;

  // Control register 0 and 1 field positions
  localparam int GO_BIT = 7;
  localparam int REF_LOW_BIT = 6;
  localparam int REF_OUT_BIT = 5;
  localparam int CONTINUOUS_SELECT_BIT = 4;
  localparam int REF_HIGH_BIT = 7;

  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic ref_high_reset = 1'b1;

  // Interrupt status bits
  localparam int EV_DONE = 0;
  localparam int EV_OVF = 1;
  localparam int EV_W = 2;

  // Reference codes
  localparam logic [1:0] REF_EXTERNAL = 2'h0;
  localparam logic [1:0] REF_1V0 = 2'h1;
  localparam logic [1:0] REF_2V0 = 2'h2;

  // Timing in system clock cycles
  localparam int CONV_CYCLES_DEF = 5129;
  localparam int REFRESH_CYCLES = 256;
  localparam int CNT_W = 15;
  localparam logic [3:0] TEMP_CHANNEL_DEF = 4'hE;

  localparam int RES_W = 13;
  localparam int RES_LO_W = 5;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic go;
    logic ref_low;
    logic ref_out;
    logic continuous_select;
    logic [3:0] channel;
  } ctrl0_t;

  typedef struct packed {
    logic start;
    logic [1:0] ref_code;
    logic ref_buf_en;
    logic [3:0] channel;
  } core_cmd_t;

  typedef struct packed {
    logic [RES_W-1:0] value;
    logic ovf;
  } sample_t;
endpackage

// ---- verilog/adc_conversion_control.sv ----
// Conversion sequencing, result latching and AHB-Lite registers of the converter

// Function
// - Writing go flag starts a conversion
// - Go write while busy restarts conversion
// - Hardware clears go flag; writing 0 ignored
// - Go flag reads 1 until the first result
// - Two-bit reference code selects reference source
// - Reference buffer enable drives reference pin
// - Single shot gives one result after 5129
// - Continuous: first 5129, then every 256
// - Temperature channel doubles both intervals
// - Control register 0 bit layout, reset zero; register 1 resets to 0x80
// - 13-bit result split over two bytes
// - High byte holds the latest result
// - High byte read latches low byte
// - Low byte bit 0 flags overflow
// - Data registers are read only
module adc_conversion_control #(
  parameter int CONV_CYCLES = adc_conv_pkg::CONV_CYCLES_DEF,
  parameter logic [3:0] TEMP_CHANNEL = adc_conv_pkg::TEMP_CHANNEL_DEF
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  output logic o_irq,
  output adc_conv_pkg::core_cmd_t o_core_cmd,
  input wire adc_conv_pkg::sample_t i_core_sample
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FIRST = 3'b010,
    ST_CONTINUOUS_SELECT = 3'b100
  } conv_state_t;

  localparam int CNT_W_L = adc_conv_pkg::CNT_W;
  localparam logic [CNT_W_L-1:0] CNT_ONE = CNT_W_L'(1);

  function automatic logic [CNT_W_L-1:0] period_last(
    input int base,
    input logic is_temp
  );
    int cycles;
    cycles = is_temp ? 2 * base : base;
    period_last = CNT_W_L'(cycles - 1);
  endfunction

  function automatic logic hit(input logic [31:0] addr, input logic [11:0] idx);
    hit = (addr[31:2] == {18'h00000, idx}) && (addr[1:0] == 2'h0);
  endfunction

  adc_conv_pkg::ctrl0_t ctrl_q;
  logic ref_high_q;
  conv_state_t state_q;
  logic [CNT_W_L-1:0] cnt_q;
  adc_conv_pkg::sample_t result_q;
  logic [7:0] low_latch_q;
  logic [adc_conv_pkg::EV_W-1:0] stat_q;
  logic [adc_conv_pkg::EV_W-1:0] mask_q;
  logic start_q;

  // Bus data phase bookkeeping
  logic wr_pend_q;
  logic rd_pend_q;
  logic [31:0] addr_q;

  logic accept;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_mask;
  logic rd_now;
  logic go_write;
  logic is_temp;
  logic [CNT_W_L-1:0] last;
  logic finish;
  logic [adc_conv_pkg::EV_W-1:0] events;
  logic [31:0] rd_word;

  assign accept = i_hsel && i_hready && (i_htrans == adc_conv_pkg::HTRANS_NONSEQ);
  assign wr_ctrl0 = wr_pend_q && hit(addr_q, adc_conv_pkg::IDX_CTRL0);
  assign wr_ctrl1 = wr_pend_q && hit(addr_q, adc_conv_pkg::IDX_CTRL1);
  assign wr_mask = wr_pend_q && hit(addr_q, adc_conv_pkg::IDX_IRQ_MASK);
  assign rd_now = rd_pend_q && !o_hreadyout;

  assign go_write = wr_ctrl0 && i_hwdata[adc_conv_pkg::GO_BIT];
  assign is_temp = (ctrl_q.channel == TEMP_CHANNEL);

  always_comb begin
    last = period_last(CONV_CYCLES, is_temp);
    if (state_q == ST_CONTINUOUS_SELECT) begin
      last = period_last(adc_conv_pkg::REFRESH_CYCLES, is_temp);
    end
  end

  assign finish = (state_q != ST_IDLE) && (cnt_q == last) && !go_write;

  assign events = {finish && i_core_sample.ovf, finish};

  // Sequencer
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else if (go_write) begin
      state_q <= ST_FIRST;
      cnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
        end
        ST_FIRST, ST_CONTINUOUS_SELECT: begin
          if (finish) begin
            cnt_q <= '0;
            state_q <= ctrl_q.continuous_select ? ST_CONTINUOUS_SELECT : ST_IDLE;
          end else begin
            cnt_q <= cnt_q + CNT_ONE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // Continuous mode ends once software clears the select bit
  // and the running period completes.

  // Control registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      ctrl_q <= adc_conv_pkg::CTRL0_RESET;
    end else begin
      if (wr_ctrl0) begin
        ctrl_q.ref_low <= i_hwdata[adc_conv_pkg::REF_LOW_BIT];
        ctrl_q.ref_out <= i_hwdata[adc_conv_pkg::REF_OUT_BIT];
        ctrl_q.continuous_select <= i_hwdata[adc_conv_pkg::CONTINUOUS_SELECT_BIT];
        ctrl_q.channel <= i_hwdata[3:0];
      end
      if (go_write) begin
        ctrl_q.go <= 1'b1;
      end else if (finish && state_q == ST_FIRST) begin
        ctrl_q.go <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      ref_high_q <= adc_conv_pkg::ref_high_reset;
    end else if (wr_ctrl1) begin
      ref_high_q <= i_hwdata[adc_conv_pkg::REF_HIGH_BIT];
    end
  end

  // Command to the analog core
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      start_q <= 1'b0;
    end else begin
      start_q <= go_write;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_core_cmd <= '0;
    end else begin
      o_core_cmd.start <= go_write;
      o_core_cmd.ref_code <= {ref_high_q, ctrl_q.ref_low};
      // External reference with buffer on is software's fault; buffer follows the bit
      o_core_cmd.ref_buf_en <= ctrl_q.ref_out;
      o_core_cmd.channel <= ctrl_q.channel;
    end
  end

  // Result capture; no reset since content is undefined until first result
  always_ff @(posedge i_ref_clk) begin
    if (finish) begin
      result_q <= i_core_sample;
    end
  end

  // Low byte snapshot taken at high byte read, so both bytes match
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      low_latch_q <= 8'h00;
    end else if (rd_now && hit(addr_q, adc_conv_pkg::IDX_RES_HI)) begin
      low_latch_q <= {result_q.value[adc_conv_pkg::RES_LO_W-1:0], 2'h0, result_q.ovf};
    end
  end

  // Interrupt status: set wins over read-clear
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      stat_q <= '0;
    end else if (rd_now && hit(addr_q, adc_conv_pkg::IDX_IRQ_STAT)) begin
      stat_q <= events;
    end else begin
      stat_q <= stat_q | events;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= i_hwdata[adc_conv_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |((stat_q | events) & mask_q);
    end
  end

  // Bus slave: writes take no wait state, reads take one
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= '0;
    end else if (o_hreadyout) begin
      wr_pend_q <= accept && i_hwrite;
      rd_pend_q <= accept && !i_hwrite;
      if (accept) begin
        addr_q <= i_haddr;
      end
    end else begin
      rd_pend_q <= 1'b0;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit(addr_q, adc_conv_pkg::IDX_CTRL0)) begin
      rd_word[7:0] = ctrl_q;
    end else if (hit(addr_q, adc_conv_pkg::IDX_CTRL1)) begin
      rd_word[adc_conv_pkg::REF_HIGH_BIT] = ref_high_q;
    end else if (hit(addr_q, adc_conv_pkg::IDX_RES_HI)) begin
      rd_word[7:0] = result_q.value[adc_conv_pkg::RES_W-1:adc_conv_pkg::RES_LO_W];
    end else if (hit(addr_q, adc_conv_pkg::IDX_RES_LO)) begin
      rd_word[7:0] = low_latch_q;
    end else if (hit(addr_q, adc_conv_pkg::IDX_IRQ_STAT)) begin
      rd_word[adc_conv_pkg::EV_W-1:0] = stat_q;
    end else if (hit(addr_q, adc_conv_pkg::IDX_IRQ_MASK)) begin
      rd_word[adc_conv_pkg::EV_W-1:0] = mask_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_hreadyout <= 1'b1;
      o_hrdata <= 32'h0000_0000;
    end else if (o_hreadyout && accept && !i_hwrite) begin
      o_hreadyout <= 1'b0;
    end else if (rd_now) begin
      o_hreadyout <= 1'b1;
      o_hrdata <= rd_word;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_hresp <= 1'b0;
    end else begin
      o_hresp <= 1'b0;
    end
  end

  logic unused_ok;
  assign unused_ok = start_q ^ ^i_hsize;

endmodule

// ---- sim/adc_core_model.sv ----
// Behavioural converter core facing the control block
module adc_core_model (
  input wire logic i_ref_clk,
  input wire adc_conv_pkg::core_cmd_t i_core_cmd,
  input wire adc_conv_pkg::sample_t i_analog,
  output adc_conv_pkg::sample_t o_core_sample,
  output logic o_ref_clash
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_ref_clash = 1'b0;
  // One flop of track delay, so a sample lags the input
  always @(posedge i_ref_clk) o_core_sample <= i_analog;
  // Driving the pin while it feeds the reference would fight the source
  always @(posedge i_ref_clk) if (i_core_cmd.ref_buf_en && i_core_cmd.ref_code == 2'h0) o_ref_clash <= 1'b1;
endmodule

// ---- sim/adc_conversion_control_assertions.sv ----
// Port assertions for the converter control block
module adc_conversion_control_assertions (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hresp,
  input wire logic o_irq,
  input wire adc_conv_pkg::core_cmd_t o_core_cmd
);
  logic take, go, wr_q, rd_q;
  logic [5:0] fld_q;
  assign take = i_hsel & i_hready & (i_htrans == 2'h2);
  assign go = wr_q & i_hwdata[7];
  always_ff @(posedge i_ref_clk) begin
    wr_q <= i_rst_b & take & i_hwrite & (i_haddr == 32'h3DC0);
    rd_q <= i_rst_b & take & ~i_hwrite;
    fld_q <= {i_hwdata[6:5], i_hwdata[3:0]};
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  sequence read_ack;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  a_go_starts: assert property (go |=> o_core_cmd.start) else $error("no start");
  a_zero_idle: assert property (wr_q && !i_hwdata[7] |=> !o_core_cmd.start) else $error("stray start");
  a_start_pulse: assert property (o_core_cmd.start && !go |=> !o_core_cmd.start) else $error("long start");
  a_ctrl_fields: assert property (wr_q |=> ##1
    {o_core_cmd.ref_code[0], o_core_cmd.ref_buf_en, o_core_cmd.channel} == $past(fld_q)) else $error("bad fields");
  a_reset_quiet: assert property (disable iff (1'b0) !i_rst_b |=> !o_core_cmd.start && !o_irq)
    else $error("busy in reset");
  a_read_wait: assert property (rd_q |-> read_ack) else $error("bad read wait");
  a_rdata_hold: assert property (!o_hreadyout |-> $stable(o_hrdata)) else $error("data moved");
  a_resp_okay: assert property (o_hresp == 1'b0) else $error("error response");
endmodule

bind adc_conversion_control adc_conversion_control_assertions u_chk (.i_ref_clk, .i_rst_b, .i_hsel, .i_haddr,
  .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hreadyout, .o_hrdata, .o_hresp, .o_irq, .o_core_cmd);

// ---- sim/adc_conversion_control_tb.sv ----
// Self-checking bench for the converter control block
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h, expected %h", $time, a, e); end end
module adc_conversion_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 20;
  logic i_ref_clk = 1'b0, i_rst_b = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0, o_hreadyout, o_irq, clash;
  logic [1:0] i_htrans = 2'h0;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, rdata;
  adc_conv_pkg::core_cmd_t o_core_cmd;
  adc_conv_pkg::sample_t i_core_sample, ana = 14'h0;
  int miscompares = 0, checks_done = 0, cyc = 0, t0;
  logic [31:0] rows [5][3] = '{'{32'h3DC4, 32'h0, 32'h0}, '{32'h3DC4, 32'h80, 32'h80},
    '{32'h3DE0, 32'hFF, 32'h0}, '{32'h3DD4, 32'h3, 32'h3}, '{32'h3DC0, 32'hFFFFFF25, 32'h25}};
  always #12.5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) cyc <= cyc + 1;
  adc_conversion_control #(.CONV_CYCLES(CONV)) DUT (.i_ref_clk, .i_rst_b, .i_hsel, .i_haddr, .i_htrans,
    .i_hwrite, .i_hsize(3'h2), .i_hwdata, .i_hready(o_hreadyout), .o_hreadyout, .o_hrdata, .o_hresp(),
    .o_irq, .o_core_cmd, .i_core_sample);
  adc_core_model core (.i_ref_clk, .i_core_cmd(o_core_cmd), .i_analog(ana), .o_core_sample(i_core_sample),
    .o_ref_clash(clash));
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_for(input logic use_irq, input int lim);
    int k = 0;
    do begin
      @(posedge i_ref_clk);
      k++;
    end while ((use_irq ? o_irq : o_hreadyout) !== 1'b1 && k < lim);
    if (k >= lim) begin
      miscompares++;
      finish_test();
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= a;
    i_hwrite <= w;
    wait_for(1'b0, 20);
    i_htrans <= 2'h0;
    i_hsel <= 1'b0;
    i_hwdata <= d;
    wait_for(1'b0, 20);
    rdata = o_hrdata;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rdata, e)
  endtask
  task automatic chk_res(input adc_conv_pkg::sample_t s);
    rdc(32'h3DC8, {24'h0, s.value[12:5]});
    rdc(32'h3DCC, {24'h0, s.value[4:0], 2'h0, s.ovf});
  endtask
  // Edges from go or last result up to the raised interrupt
  task automatic conv_time(input int lo);
    wait_for(1'b1, 3000);
    `CHK((cyc - t0) inside {[lo:lo + 2]}, 1'b1)
  endtask
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(posedge i_ref_clk);
    rdc(32'h3DC0, 32'h0);
    rdc(32'h3DC4, 32'h80);
    $display("reset test done");
    foreach (rows[i]) begin
      xfer(1'b1, rows[i][0], rows[i][1]);
      rdc(rows[i][0], rows[i][2]);
    end
    `CHK({o_core_cmd.ref_code, o_core_cmd.ref_buf_en, o_core_cmd.channel}, 7'h55)
    $display("register rows done");
    ana <= '{13'h1A5B, 1'b1};
    xfer(1'b1, 32'h3DC0, 32'h83);
    t0 = cyc;
    rdc(32'h3DC0, 32'h83);
    conv_time(CONV);
    chk_res(ana);
    rdc(32'h3DC0, 32'h03);
    rdc(32'h3DD0, 32'h03);
    repeat (300) @(posedge i_ref_clk);
    `CHK(o_irq, 1'b0)
    $display("single shot done");
    xfer(1'b1, 32'h3DC0, 32'h81);
    repeat (8) @(posedge i_ref_clk);
    xfer(1'b1, 32'h3DC0, 32'h81);
    t0 = cyc;
    repeat (5) @(posedge i_ref_clk);
    xfer(1'b1, 32'h3DC0, 32'h01);
    conv_time(CONV);
    rdc(32'h3DD0, 32'h03);
    xfer(1'b1, 32'h3DC0, 32'h8E);
    t0 = cyc;
    conv_time(2 * CONV);
    xfer(1'b1, 32'h3DD4, 32'h0);
    repeat (2) @(posedge i_ref_clk);
    `CHK(o_irq, 1'b0)
    rdc(32'h3DD0, 32'h03);
    xfer(1'b1, 32'h3DD4, 32'h03);
    $display("restart and temperature done");
    xfer(1'b1, 32'h3DC0, 32'h90);
    t0 = cyc;
    conv_time(CONV);
    t0 = cyc;
    chk_res(ana);
    ana <= '{13'h0ABC, 1'b0};
    rdc(32'h3DD0, 32'h03);
    repeat (3) @(posedge i_ref_clk);
    conv_time(256);
    rdc(32'h3DCC, 32'hD9);
    chk_res(ana);
    rdc(32'h3DC0, 32'h10);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(posedge i_ref_clk);
    rdc(32'h3DC0, 32'h0);
    `CHK(clash, 1'b0)
    $display("continuous and reset done");
    finish_test();
  end
endmodule
